// ### hdl/cfg_port_pkg.sv
// Constants and types shared by the serial configuration and EEPROM port
package cfg_port_pkg;
    // Target addresses
    localparam logic [6:0] ADDR_REF_FLOAT = 7'h67;
    localparam logic [5:0] ADDR_UPPER = 6'h34;
    localparam logic ADDR_LSB_FALLBACK = 1'h0;
    // EEPROM organisation: base page, page 0, page 1, 64 words each
    localparam int NVM_TOTAL_WORDS = 192;
    localparam logic [5:0] NVM_LAST_WORD = 6'h3f;
    localparam logic [1:0] PAGE_BASE = 2'h0;
    localparam logic [1:0] PAGE_ZERO = 2'h1;
    localparam logic [1:0] PAGE_ONE = 2'h2;
    // Boot configuration word in the selected page
    localparam logic [5:0] CFG_WORD = 6'h03;
    localparam int CFG_LSB_BIT = 0;
    localparam int CFG_EN_BIT = 1;
    // Write unlock value
    localparam logic [3:0] UNLOCK = 4'h5;
    // Internal register offsets
    localparam logic [15:0] OFF_CTRL = 16'h0001;
    localparam logic [15:0] OFF_NVM_ADDR = 16'h0002;
    localparam logic [15:0] OFF_NVM_DATA = 16'h0003;
    localparam logic [15:0] OFF_CRC = 16'h0004;
    localparam logic [15:0] OFF_STATUS = 16'h0005;
    // Control register field positions
    localparam int CTRL_COMMIT_BIT = 0;
    localparam int CTRL_CRC_BIT = 1;
    localparam int CTRL_VCO_RECALIBRATE_BIT_BIT = 2;
    localparam int CTRL_PAGE_BIT = 3;
    localparam int CTRL_LOCK_LSB = 4;
    // Reset values and checksum polynomial
    localparam logic [3:0] LOCK_RESET = 4'h0;
    localparam logic [15:0] CRC_INIT = 16'hffff;
    localparam logic [15:0] CRC_POLY = 16'h1021;
    // Timing
    localparam int CLK_HZ = 50_000_000;
    localparam int NVM_WRITE_MS = 8;
    localparam int NVM_WRITE_CYCLES = NVM_WRITE_MS * (CLK_HZ / 1000);
    localparam logic [1:0] BOOT_SETTLE = 2'h3;

    typedef enum logic [1:0] {
        LVL_LOW = 2'h0,
        LVL_HIGH = 2'h1,
        LVL_MID = 2'h2
    } tri_level_t;

    typedef struct packed {
        logic [15:0] offset;
        logic [15:0] value;
    } reg_access_t;
endpackage

// ### hdl/serial_config_eeprom_port.sv
// Serial configuration target with EEPROM checksum, commit and direct write engine
// Function
// - Serves standard and fast mode serial clocks by oversampling with the core clock.
// - Fall-back with floating reference select answers on address 67h.
// - Other modes use 68h or 69h when enabled; interface disabled by default.
// - In page 0 or page 1 boot, address LSB comes from a stored bit of the selected page.
// - Upper six address bits fixed except for 67h; page-select mid with reference driven gives 68h.
// - Read/write bit after address: one reads, zero writes.
// - Page 0 or page 1 boot takes serial enable from a stored bit of the page; cleared gives pin mode.
// - Transfer is address byte, 16-bit offset, then 16-bit value.
// - Start-up reads whole selected page, computes checksum, compares stored word, records result.
// - Writing one to checksum update bit reruns checksum and refreshes status.
// - Checksum mismatch is status only, never blocks operation.
// - Checksum uses polynomial x^16 + x^12 + x^5 + 1.
// - Each EEPROM word write takes 8 ms before the word is usable.
// - Commit copies all register bits into the chosen EEPROM page.
// - Each EEPROM page holds 64 words of 16 bits, addresses 0 through 63.
// - Each unlocked data field write made while the EEPROM is idle programs current address then increments it.
// - Base page plus page 0 and 1; page-select low/high chooses page.
// - Page-select sampled once after power-up; mid level selects default with interface.
// - Fall-back skips EEPROM read, boots defaults, interface stays active.
`timescale 1ns/1ps
module serial_config_eeprom_port #(
    parameter int unsigned WRITE_CYCLES = cfg_port_pkg::NVM_WRITE_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic [1:0] page_select_pin,
    input wire logic [1:0] reference_select_pin,
    input wire logic [15:0] commit_word_data,
    output logic [5:0] commit_word_index,
    output logic i2c_enabled,
    output logic pin_mode,
    output logic fallback_mode,
    output logic [6:0] target_address,
    output logic crc_match,
    output logic [15:0] live_checksum_value,
    output logic nvm_busy,
    output logic vco_recalibrate_bit,
    output logic reg_wr_valid,
    output cfg_port_pkg::reg_access_t reg_wr
);
    typedef enum logic [5:0] {
        I_IDLE = 6'h01, I_ADDR = 6'h02, I_ACK = 6'h04,
        I_WRITE = 6'h08, I_READ = 6'h10, I_RACK = 6'h20
    } i2c_state_t;
    typedef enum logic [3:0] {
        N_IDLE = 4'h1, N_CRC = 4'h2, N_PROG = 4'h4, N_WAIT = 4'h8
    } nvm_state_t;

    logic [15:0] nvm_mem [0:cfg_port_pkg::NVM_TOTAL_WORDS-1];
    logic [5:0] sync1_r, sync2_r;
    logic scl_d_r, sda_d_r;
    logic scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det;
    logic [1:0] page_s, ref_s;
    i2c_state_t i_state_r;
    nvm_state_t n_state_r;
    logic [2:0] bit_cnt_r;
    logic [7:0] shift_r, byte_in, rd_byte;
    logic [1:0] byte_idx_r;
    logic rw_r, ack_on_r, rd_lo_r, sda_oe_r;
    logic [15:0] offset_r, rd_word;
    logic [7:0] value_hi_r;
    logic wr_stb, addr_hit;
    logic [15:0] wr_value;
    logic [1:0] boot_cnt_r, boot_page_r;
    logic boot_done_r, boot_go_r, fallback_r, en_r;
    logic [6:0] addr_r;
    logic [15:0] cfg_word;
    logic [3:0] lock_r;
    logic page_r, vco_recalibrate_bit_r, wr_valid_r;
    logic [5:0] nvm_addr_r, idx_r;
    logic [15:0] wdata_r, crc_r, live_r;
    logic match_r, commit_run_r;
    logic [1:0] op_page_r;
    logic [19:0] timer_r;
    logic commit_go, direct_go, crc_go, is_internal;
    cfg_port_pkg::reg_access_t reg_wr_r;
    logic mem_we;
    logic [7:0] mem_idx;
    logic [15:0] mem_wdata;

    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [15:0] d);
        logic [15:0] r;
        r = c;
        for (int i = 15; i >= 0; i--) begin
            if (r[15] ^ d[i]) begin
                r = {r[14:0], 1'b0} ^ cfg_port_pkg::CRC_POLY;
            end else begin
                r = {r[14:0], 1'b0};
            end
        end
        return r;
    endfunction

    function automatic logic is_mid(input logic [1:0] lvl);
        return lvl == cfg_port_pkg::LVL_MID;
    endfunction

    // Pin synchronisers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_r <= 6'h3f;
            sync2_r <= 6'h3f;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            sync1_r <= {scl_in, sda_in, page_select_pin, reference_select_pin};
            sync2_r <= sync1_r;
            scl_d_r <= sync2_r[5];
            sda_d_r <= sync2_r[4];
        end
    end

    assign scl_s = sync2_r[5];
    assign sda_s = sync2_r[4];
    assign page_s = sync2_r[3:2];
    assign ref_s = sync2_r[1:0];
    assign scl_rise = scl_s & ~scl_d_r;
    assign scl_fall = ~scl_s & scl_d_r;
    assign start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
    assign stop_det = scl_s & scl_d_r & ~sda_d_r & sda_s;
    assign byte_in = {shift_r[6:0], sda_s};
    assign addr_hit = en_r && boot_done_r && (byte_in[7:1] == addr_r);
    assign wr_stb = (i_state_r == I_WRITE) && scl_rise && (bit_cnt_r == 3'h7)
        && (byte_idx_r == 2'h3);
    assign wr_value = {value_hi_r, byte_in};
    assign rd_byte = rd_lo_r ? rd_word[7:0] : rd_word[15:8];
    assign cfg_word = nvm_mem[{boot_page_r, cfg_port_pkg::CFG_WORD}];

    always_comb begin
        unique case (offset_r)
            cfg_port_pkg::OFF_CTRL: rd_word = {8'h00, lock_r, page_r, 3'h0};
            cfg_port_pkg::OFF_NVM_ADDR: rd_word = {10'h000, nvm_addr_r};
            cfg_port_pkg::OFF_CRC: rd_word = live_r;
            cfg_port_pkg::OFF_STATUS: rd_word = {14'h0000, n_state_r != N_IDLE, match_r};
            default: rd_word = 16'h0000;
        endcase
    end

    // Serial target protocol
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            i_state_r <= I_IDLE;
            bit_cnt_r <= 3'h0;
            shift_r <= 8'h00;
            byte_idx_r <= 2'h0;
            rw_r <= 1'b0;
            ack_on_r <= 1'b0;
            rd_lo_r <= 1'b0;
            sda_oe_r <= 1'b0;
            offset_r <= 16'h0000;
            value_hi_r <= 8'h00;
        end else if (start_det) begin
            i_state_r <= I_ADDR;
            bit_cnt_r <= 3'h0;
            ack_on_r <= 1'b0;
            sda_oe_r <= 1'b0;
        end else if (stop_det) begin
            i_state_r <= I_IDLE;
            sda_oe_r <= 1'b0;
        end else begin
            unique case (i_state_r)
                I_IDLE: begin
                end
                I_ADDR, I_WRITE: if (scl_rise) begin
                    shift_r <= byte_in;
                    bit_cnt_r <= bit_cnt_r + 3'h1;
                    if (bit_cnt_r == 3'h7) begin
                        if (i_state_r == I_WRITE) begin
                            byte_idx_r <= byte_idx_r + 2'h1;
                            i_state_r <= I_ACK;
                            unique case (byte_idx_r)
                                2'h0: offset_r[15:8] <= byte_in;
                                2'h1: offset_r[7:0] <= byte_in;
                                2'h2: value_hi_r <= byte_in;
                                2'h3: begin
                                end
                            endcase
                        end else if (addr_hit) begin
                            rw_r <= byte_in[0];
                            byte_idx_r <= 2'h0;
                            rd_lo_r <= 1'b0;
                            i_state_r <= I_ACK;
                        end else begin
                            i_state_r <= I_IDLE;
                        end
                    end
                end
                I_ACK: if (scl_fall) begin
                    if (!ack_on_r) begin
                        sda_oe_r <= 1'b1;
                        ack_on_r <= 1'b1;
                    end else if (rw_r) begin
                        ack_on_r <= 1'b0;
                        shift_r <= rd_byte;
                        sda_oe_r <= ~rd_byte[7];
                        rd_lo_r <= ~rd_lo_r;
                        bit_cnt_r <= 3'h0;
                        i_state_r <= I_READ;
                    end else begin
                        ack_on_r <= 1'b0;
                        sda_oe_r <= 1'b0;
                        i_state_r <= I_WRITE;
                    end
                end
                I_READ: if (scl_fall) begin
                    bit_cnt_r <= bit_cnt_r + 3'h1;
                    if (bit_cnt_r == 3'h7) begin
                        sda_oe_r <= 1'b0;
                        i_state_r <= I_RACK;
                    end else begin
                        shift_r <= {shift_r[6:0], 1'b0};
                        sda_oe_r <= ~shift_r[6];
                    end
                end
                I_RACK: if (scl_rise) begin
                    if (sda_s) begin
                        i_state_r <= I_IDLE;
                    end else begin
                        ack_on_r <= 1'b1;
                    end
                end else if (scl_fall && ack_on_r) begin
                    ack_on_r <= 1'b0;
                    shift_r <= rd_byte;
                    sda_oe_r <= ~rd_byte[7];
                    rd_lo_r <= ~rd_lo_r;
                    bit_cnt_r <= 3'h0;
                    i_state_r <= I_READ;
                end
            endcase
        end
    end

    // Mode and address selection, sampled once after reset release
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            boot_cnt_r <= 2'h0;
            boot_done_r <= 1'b0;
            boot_go_r <= 1'b0;
            boot_page_r <= cfg_port_pkg::PAGE_BASE;
            fallback_r <= 1'b0;
            en_r <= 1'b0;
            addr_r <= {cfg_port_pkg::ADDR_UPPER, cfg_port_pkg::ADDR_LSB_FALLBACK};
        end else if (!boot_done_r) begin
            boot_cnt_r <= boot_cnt_r + 2'h1;
            if (boot_cnt_r == cfg_port_pkg::BOOT_SETTLE) begin
                boot_done_r <= 1'b1;
                boot_page_r <= (page_s == cfg_port_pkg::LVL_HIGH) ?
                    cfg_port_pkg::PAGE_ONE : cfg_port_pkg::PAGE_ZERO;
                if (is_mid(ref_s)) begin
                    fallback_r <= 1'b1;
                    en_r <= 1'b1;
                    addr_r <= cfg_port_pkg::ADDR_REF_FLOAT;
                end else if (is_mid(page_s)) begin
                    fallback_r <= 1'b1;
                    en_r <= 1'b1;
                    addr_r <= {cfg_port_pkg::ADDR_UPPER, cfg_port_pkg::ADDR_LSB_FALLBACK};
                end else begin
                    boot_go_r <= 1'b1;
                end
            end
        end else begin
            boot_go_r <= 1'b0;
            if (boot_go_r) begin
                en_r <= cfg_word[cfg_port_pkg::CFG_EN_BIT];
                addr_r <= {cfg_port_pkg::ADDR_UPPER, cfg_word[cfg_port_pkg::CFG_LSB_BIT]};
            end
        end
    end

    assign is_internal = (offset_r == cfg_port_pkg::OFF_CTRL)
        || (offset_r == cfg_port_pkg::OFF_NVM_ADDR) || (offset_r == cfg_port_pkg::OFF_NVM_DATA)
        || (offset_r == cfg_port_pkg::OFF_CRC) || (offset_r == cfg_port_pkg::OFF_STATUS);
    assign commit_go = wr_stb && (offset_r == cfg_port_pkg::OFF_CTRL) && (n_state_r == N_IDLE)
        && wr_value[cfg_port_pkg::CTRL_COMMIT_BIT] && (lock_r == cfg_port_pkg::UNLOCK);
    assign direct_go = wr_stb && (offset_r == cfg_port_pkg::OFF_NVM_DATA)
        && (n_state_r == N_IDLE) && (lock_r == cfg_port_pkg::UNLOCK);
    assign crc_go = boot_go_r || (wr_stb && (offset_r == cfg_port_pkg::OFF_CTRL)
        && (n_state_r == N_IDLE) && wr_value[cfg_port_pkg::CTRL_CRC_BIT]);

    // Control fields and pass-through of device register writes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lock_r <= cfg_port_pkg::LOCK_RESET;
            page_r <= 1'b0;
            vco_recalibrate_bit_r <= 1'b0;
            nvm_addr_r <= 6'h00;
            wr_valid_r <= 1'b0;
            reg_wr_r <= '0;
        end else begin
            vco_recalibrate_bit_r <= wr_stb && (offset_r == cfg_port_pkg::OFF_CTRL)
                && wr_value[cfg_port_pkg::CTRL_VCO_RECALIBRATE_BIT_BIT];
            wr_valid_r <= wr_stb && !is_internal;
            if (wr_stb) begin
                reg_wr_r <= '{offset: offset_r, value: wr_value};
            end
            if (wr_stb && (offset_r == cfg_port_pkg::OFF_CTRL)) begin
                lock_r <= wr_value[cfg_port_pkg::CTRL_LOCK_LSB +: 4];
                page_r <= wr_value[cfg_port_pkg::CTRL_PAGE_BIT];
            end
            if (wr_stb && (offset_r == cfg_port_pkg::OFF_NVM_ADDR)) begin
                nvm_addr_r <= wr_value[5:0];
            end else if (direct_go) begin
                nvm_addr_r <= nvm_addr_r + 6'h01;
            end
        end
    end

    // EEPROM checksum and programming engine
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            n_state_r <= N_IDLE;
            idx_r <= 6'h00;
            op_page_r <= cfg_port_pkg::PAGE_BASE;
            wdata_r <= 16'h0000;
            crc_r <= cfg_port_pkg::CRC_INIT;
            live_r <= 16'h0000;
            match_r <= 1'b0;
            commit_run_r <= 1'b0;
            timer_r <= 20'h00000;
        end else begin
            unique case (n_state_r)
                N_IDLE: if (crc_go) begin
                    idx_r <= 6'h00;
                    crc_r <= cfg_port_pkg::CRC_INIT;
                    op_page_r <= boot_go_r ? boot_page_r : (page_r ? cfg_port_pkg::PAGE_ONE :
                        cfg_port_pkg::PAGE_ZERO);
                    n_state_r <= N_CRC;
                end else if (commit_go) begin
                    idx_r <= 6'h00;
                    commit_run_r <= 1'b1;
                    op_page_r <= page_r ? cfg_port_pkg::PAGE_ONE : cfg_port_pkg::PAGE_ZERO;
                    n_state_r <= N_PROG;
                end else if (direct_go) begin
                    idx_r <= nvm_addr_r;
                    wdata_r <= wr_value;
                    op_page_r <= page_r ? cfg_port_pkg::PAGE_ONE : cfg_port_pkg::PAGE_ZERO;
                    n_state_r <= N_PROG;
                end
                N_CRC: begin
                    if (idx_r == cfg_port_pkg::NVM_LAST_WORD) begin
                        live_r <= crc_r;
                        match_r <= crc_r == nvm_mem[{op_page_r, idx_r}];
                        n_state_r <= N_IDLE;
                    end else begin
                        crc_r <= crc_step(crc_r, nvm_mem[{op_page_r, idx_r}]);
                        idx_r <= idx_r + 6'h01;
                    end
                end
                N_PROG: begin
                    timer_r <= 20'(WRITE_CYCLES - 1);
                    n_state_r <= N_WAIT;
                end
                N_WAIT: begin
                    if (timer_r != 20'h00000) begin
                        timer_r <= timer_r - 20'h00001;
                    end else if (commit_run_r && (idx_r != cfg_port_pkg::NVM_LAST_WORD)) begin
                        idx_r <= idx_r + 6'h01;
                        n_state_r <= N_PROG;
                    end else begin
                        commit_run_r <= 1'b0;
                        n_state_r <= N_IDLE;
                    end
                end
            endcase
        end
    end

    assign mem_we = n_state_r == N_PROG;
    assign mem_idx = {op_page_r, idx_r};
    assign mem_wdata = commit_run_r ? commit_word_data : wdata_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < cfg_port_pkg::NVM_TOTAL_WORDS; i++) begin
                nvm_mem[i] <= 16'h0000;
            end
        end else if (mem_we) begin
            nvm_mem[mem_idx] <= mem_wdata;
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe = sda_oe_r;
    assign commit_word_index = idx_r;
    assign i2c_enabled = en_r;
    assign pin_mode = boot_done_r && !en_r;
    assign fallback_mode = fallback_r;
    assign target_address = addr_r;
    assign crc_match = match_r;
    assign live_checksum_value = live_r;
    assign nvm_busy = n_state_r != N_IDLE;
    assign vco_recalibrate_bit = vco_recalibrate_bit_r;
    assign reg_wr_valid = wr_valid_r;
    assign reg_wr = reg_wr_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_no_ack_disabled: assert property (!en_r |-> !sda_oe_r)
        else $error("target drove the data line while disabled");
    chk_fallback_address: assert property (boot_done_r && is_mid(ref_s) && $rose(fallback_r)
        |-> addr_r == 7'h67)
        else $error("floating reference select did not give 67h");
    chk_serial_address: assert property ($rose(boot_done_r) && fallback_r && !is_mid($past(ref_s))
        |-> addr_r == 7'h68)
        else $error("mid page select did not give 68h");
    chk_pin_mode_off: assert property ($rose(boot_done_r) && !fallback_r |=> ##1 (en_r ==
        cfg_word[cfg_port_pkg::CFG_EN_BIT]))
        else $error("enable does not follow the stored page bit");
    chk_lock_gate: assert property ($rose(n_state_r == N_PROG) && !commit_run_r
        |-> $past(lock_r) == 4'h5)
        else $error("EEPROM programmed without unlock");
    chk_addr_incr: assert property (direct_go |=> nvm_addr_r == $past(nvm_addr_r) + 6'h01)
        else $error("word address did not advance after a data write");
    chk_crc_restart: assert property (crc_go |=> n_state_r == N_CRC ##64 n_state_r == N_IDLE)
        else $error("checksum pass did not run 64 cycles");
    chk_write_hold: assert property (n_state_r == N_WAIT && timer_r != 20'h00000
        |=> n_state_r == N_WAIT)
        else $error("write wait ended early");
    chk_read_bit: assert property ((i_state_r == I_ADDR) && scl_rise && bit_cnt_r == 3'h7
        && addr_hit && sda_s |=> rw_r)
        else $error("read bit not captured");

    cov_fallback_boot: cover property ($rose(fallback_r));
    cov_crc_match: cover property ($rose(match_r));
    cov_direct_write: cover property (direct_go);
    cov_commit: cover property (commit_go);
endmodule

// ### verif/i2c_ctrl_model.sv
// Serial bus controller model that drives the clock and the open-drain data line
`timescale 1ns/1ps
module i2c_ctrl_model (
    input wire logic clk,
    input wire logic sda_oe,
    output logic scl,
    output logic sda
);
    logic drive_low;
    // Pull-up: released line reads high
    assign sda = !(drive_low || sda_oe);
    initial begin
        scl = 1'b1;
        drive_low = 1'b0;
    end
    task automatic half();
        repeat (4) @(posedge clk);
    endtask
    // Data changes only while the clock is low
    task automatic put_bit(input logic b, output logic seen);
        @(posedge clk) drive_low <= !b;
        repeat (3) @(posedge clk);
        scl <= 1'b1;
        repeat (3) @(posedge clk);
        seen = sda;
        @(posedge clk) scl <= 1'b0;
    endtask
    // Eight bits high first, then the ninth bit is left to the target
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic seen;
        for (int i = 7; i >= 0; i--) begin
            put_bit(b[i], seen);
        end
        put_bit(1'b1, seen);
        ack = (seen === 1'b0);
    endtask
    // Address with write bit, offset, value, high byte first
    task automatic write_frame(input logic [6:0] a, input logic [15:0] off,
                               input logic [15:0] val, output logic [4:0] acks);
        logic [7:0] bytes [5];
        bytes = '{{a, 1'b0}, off[15:8], off[7:0], val[15:8], val[7:0]};
        acks = 5'h00;
        half();
        drive_low <= 1'b1;
        half();
        scl <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            send_byte(bytes[i], acks[4 - i]);
            if (!acks[4 - i]) break;
        end
        @(posedge clk) drive_low <= 1'b1;
        half();
        scl <= 1'b1;
        half();
        drive_low <= 1'b0;
        half();
    endtask
endmodule

// ### verif/serial_config_eeprom_port_tb.sv
// Self-checking bench for the serial configuration and EEPROM port
`timescale 1ns/1ps
module serial_config_eeprom_port_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] page_pin = 2'h2;
    logic [1:0] ref_pin = 2'h2;
    logic scl;
    logic sda;
    logic sda_oe;
    logic [6:0] target_address;
    logic i2c_enabled;
    logic pin_mode;
    logic fallback_mode;
    logic crc_match;
    logic [15:0] live_checksum_value;
    logic reg_wr_valid;
    cfg_port_pkg::reg_access_t reg_wr;
    cfg_port_pkg::reg_access_t got_wr;
    logic [4:0] acks;
    logic [15:0] crc;
    int num_errors = 0;
    int total_checks = 0;
    int wr_count = 0;
    always #10 clk = ~clk;
    serial_config_eeprom_port #(.WRITE_CYCLES(20)) dut_u (
        .clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe(sda_oe),
        .page_select_pin(page_pin), .reference_select_pin(ref_pin),
        .commit_word_data(16'h0000), .commit_word_index(), .i2c_enabled(i2c_enabled),
        .pin_mode(pin_mode), .fallback_mode(fallback_mode), .target_address(target_address),
        .crc_match(crc_match), .live_checksum_value(live_checksum_value), .nvm_busy(),
        .vco_recalibrate_bit(), .reg_wr_valid(reg_wr_valid), .reg_wr(reg_wr)
    );
    i2c_ctrl_model host_u (.clk(clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));
    always @(posedge clk) begin
        if (reg_wr_valid === 1'b1) begin
            got_wr <= reg_wr;
            wr_count <= wr_count + 1;
        end
    end
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Power-down held low while the pins settle, then released
    task automatic boot(input logic [1:0] pg, input logic [1:0] rf);
        rst_n <= 1'b0;
        page_pin <= pg;
        ref_pin <= rf;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (120) @(posedge clk);
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #400000;
        num_errors++;
        report_and_stop();
    end
    initial begin
        crc = cfg_port_pkg::CRC_INIT;
        repeat (63 * 16) crc = {crc[14:0], 1'b0} ^ (crc[15] ? cfg_port_pkg::CRC_POLY : 16'h0);
        boot(2'h1, 2'h2);
        check(target_address, 7'h67);
        check({fallback_mode, i2c_enabled}, 2'b11);
        check(live_checksum_value, 16'h0000);
        host_u.write_frame(7'h67, 16'h0010, 16'habcd, acks);
        check(acks, 5'h1f);
        check({wr_count, got_wr}, {32'd1, 16'h0010, 16'habcd});
        host_u.write_frame(7'h68, 16'h0010, 16'h1234, acks);
        check({acks, wr_count}, {5'h00, 32'd1});
        boot(2'h2, 2'h0);
        check(target_address, 7'h68);
        host_u.write_frame(7'h68, 16'h0020, 16'h5a5a, acks);
        check({acks, got_wr}, {5'h1f, 16'h0020, 16'h5a5a});
        // Unlock, point at the checksum word, store the expected sum, then rerun it
        host_u.write_frame(7'h68, 16'h0001, 16'h0050, acks);
        check(acks, 5'h1f);
        host_u.write_frame(7'h68, 16'h0002, 16'h003f, acks);
        check(acks, 5'h1f);
        host_u.write_frame(7'h68, 16'h0003, crc, acks);
        check(acks, 5'h1f);
        host_u.write_frame(7'h68, 16'h0001, 16'h0052, acks);
        repeat (80) @(posedge clk);
        check({crc_match, live_checksum_value}, {1'b1, crc});
        for (int p = 0; p < 2; p++) begin
            boot(p[1:0], 2'h1);
            check({pin_mode, i2c_enabled, fallback_mode}, 3'b100);
            check(target_address, 7'h68);
            check(live_checksum_value, crc);
            check(crc_match, crc == 16'h0000);
            host_u.write_frame(7'h68, 16'h0010, 16'h1111, acks);
            check(acks, 5'h00);
        end
        report_and_stop();
    end
endmodule
